// ==== rtl/clp_pkg.sv ====
// Shared constants and types for the low-power, break and decode core slice.
// Assumes one 125 MHz core clock and a byte-wide memory answering in the same cycle.
package clp_pkg;

  // Opcodes decoded by this slice
  localparam logic [7:0] OP_ADC_IMM   = 8'hA9;
  localparam logic [7:0] OP_STK_ADD   = 8'hA7;
  localparam logic [7:0] OP_IDX_ADD   = 8'hAF;
  localparam logic [7:0] OP_BR_NC     = 8'h24;
  localparam logic [7:0] OP_SOFT_TRAP = 8'h83;
  localparam logic [7:0] OP_TRAP_RET  = 8'h80;
  localparam logic [7:0] OP_WAIT      = 8'h8F;
  localparam logic [7:0] OP_STOP      = 8'h8E;
  localparam logic [7:0] OP_MASK_CLR  = 8'h9A;
  localparam logic [7:0] OP_MASK_SET  = 8'h9B;

  // Vector pair addresses (high byte first)
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP     = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP_MON = 16'hFEFC;
  localparam logic [15:0] VEC_IRQ      = 16'hFFFA;

  // Register reset values and flag positions
  localparam logic [15:0] STK_RST   = 16'h00FF;
  localparam logic [7:0]  FLG_FIXED = 8'h60;
  localparam logic [7:0]  FLG_RST   = 8'h68;
  localparam int          FLG_C     = 0;
  localparam int          FLG_Z     = 1;
  localparam int          FLG_N     = 2;
  localparam int          FLG_I     = 3;
  localparam int          FLG_H     = 4;
  localparam int          FLG_V     = 7;
  localparam logic [2:0]  STACK_LAST = 3'h4;

  // Oscillator stabilization after stop
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          STAB_TIME_NS  = 2000;
  localparam logic [15:0] STAB_CYCLES   = 16'((STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] index_pair;
    logic [15:0] stack_pointer;
    logic [15:0] fetch_cursor;
    logic [7:0]  flags_register;
  } clp_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic [7:0]  wdata;
  } clp_bus_t;

  typedef enum {
    S_VEC, S_FETCH, S_EXEC1, S_EXEC2, S_STACK, S_PULL, S_WAIT, S_STOP, S_STAB
  } clp_state_t;

endpackage

// ==== rtl/clp_alu.sv ====
// Add-with-carry and signed 16-bit pointer adder.
// Purely combinational; the caller registers all results.
`timescale 1ns/1ps
module clp_alu (
  // Byte arithmetic
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  opnd,
  input  wire logic [7:0]  flags_in,
  output logic      [7:0]  sum,
  output logic      [7:0]  flags_out,
  // Pointer arithmetic
  input  wire logic [15:0] ptr,
  output logic      [15:0] ptr_sum
);
  logic [8:0] full;
  logic [4:0] half;

  always_comb begin
    full = {1'b0, acc} + {1'b0, opnd} + {8'h00, flags_in[clp_pkg::FLG_C]};
    half = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, flags_in[clp_pkg::FLG_C]};
    sum  = full[7:0];
    flags_out = flags_in;
    flags_out[clp_pkg::FLG_C] = full[8];
    flags_out[clp_pkg::FLG_H] = half[4];
    flags_out[clp_pkg::FLG_N] = full[7];
    flags_out[clp_pkg::FLG_Z] = (full[7:0] == 8'h00);
    flags_out[clp_pkg::FLG_V] = (acc[7] == opnd[7]) && (full[7] != acc[7]);
    ptr_sum = ptr + {{8{opnd[7]}}, opnd};
  end
endmodule // clp_alu

// ==== rtl/clp_stab_timer.sv ====
// Oscillator stabilization counter used on the way out of stop.
// Start is a one-cycle pulse; done pulses once when the delay has run out.
`timescale 1ns/1ps
module clp_stab_timer (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  output logic      done
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_done;

  always_comb begin
    next_done = (cnt == 16'h0001);
    if (start) begin
      next_cnt = clp_pkg::STAB_CYCLES;
    end else if (cnt != 16'h0000) begin
      next_cnt = cnt - 16'h0001;
    end else begin
      next_cnt = cnt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt  <= 16'h0000;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule // clp_stab_timer

// ==== rtl/clp_core.sv ====
// Core sequencer: low-power entry and exit, break trap, and a few decoded instructions.
// Assumes memory returns read data in the cycle the address is presented.
`timescale 1ns/1ps
module clp_core (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Memory bus
  output clp_pkg::clp_bus_t         mem_bus,
  input  wire logic [7:0]           mem_rdata,
  // Break and interrupt sources
  input  wire logic                 brk_req,
  input  wire logic                 monitor_mode,
  input  wire logic                 irq_req,
  input  wire logic                 ext_irq,
  // Status
  output clp_pkg::clp_regs_t        core_regs,
  output logic                      cpu_clk_en,
  output logic                      brk_active
);
  clp_pkg::clp_state_t st;
  clp_pkg::clp_state_t next_st;
  clp_pkg::clp_regs_t  next_regs;
  clp_pkg::clp_bus_t   next_bus;
  logic [7:0]          ir;
  logic [7:0]          next_ir;
  logic [7:0]          opnd;
  logic [7:0]          next_opnd;
  logic [2:0]          step;
  logic [2:0]          next_step;
  logic [15:0]         vec;
  logic [15:0]         next_vec;
  logic                next_brk;
  logic                next_clk_en;
  logic                enter_trap;
  logic                timer_start;
  logic                stab_done;
  logic [7:0]          adc_sum;
  logic [7:0]          adc_flags;
  logic [15:0]         ptr_in;
  logic [15:0]         ptr_sum;
  logic [7:0]          alu_opnd;
  logic [7:0]          stack_item;

  always_comb begin
    if (ir == clp_pkg::OP_IDX_ADD) begin
      ptr_in = core_regs.index_pair;
    end else if (ir == clp_pkg::OP_BR_NC) begin
      ptr_in = core_regs.fetch_cursor;
    end else begin
      ptr_in = core_regs.stack_pointer;
    end
    alu_opnd = (st == clp_pkg::S_EXEC2) ? opnd : mem_rdata;
  end

  clp_alu u_alu (
    .acc       (core_regs.acc),
    .opnd      (alu_opnd),
    .flags_in  (core_regs.flags_register),
    .sum       (adc_sum),
    .flags_out (adc_flags),
    .ptr       (ptr_in),
    .ptr_sum   (ptr_sum)
  );

  clp_stab_timer u_stab (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (timer_start),
    .done    (stab_done)
  );

  // Byte pushed after the one in flight
  always_comb begin
    unique case (step)
      3'h0:    stack_item = core_regs.fetch_cursor[15:8];
      3'h1:    stack_item = core_regs.index_pair[7:0];
      3'h2:    stack_item = core_regs.acc;
      default: stack_item = core_regs.flags_register;
    endcase
  end

  always_comb begin
    next_st     = st;
    next_regs   = core_regs;
    next_bus    = mem_bus;
    next_ir     = ir;
    next_opnd   = opnd;
    next_step   = step;
    next_vec    = vec;
    next_brk    = brk_active;
    next_clk_en = cpu_clk_en;
    enter_trap  = 1'b0;
    timer_start = 1'b0;
    unique case (st)
      clp_pkg::S_VEC: begin
        if (step == 3'h0) begin
          next_regs.fetch_cursor[15:8] = mem_rdata;
          next_bus.addr = vec + 16'h0001;
          next_step = 3'h1;
        end else begin
          next_regs.fetch_cursor[7:0] = mem_rdata;
          next_bus.addr = {core_regs.fetch_cursor[15:8], mem_rdata};
          next_step = 3'h0;
          next_st = clp_pkg::S_FETCH;
        end
      end
      clp_pkg::S_FETCH: begin
        if (brk_req && !brk_active) begin
          next_ir  = clp_pkg::OP_SOFT_TRAP;
          next_brk = 1'b1;
          next_vec = monitor_mode ? clp_pkg::VEC_TRAP_MON : clp_pkg::VEC_TRAP;
          enter_trap = 1'b1;
        end else if (irq_req && !core_regs.flags_register[clp_pkg::FLG_I]) begin
          next_vec = clp_pkg::VEC_IRQ;
          enter_trap = 1'b1;
        end else begin
          next_ir = mem_rdata;
          next_regs.fetch_cursor = core_regs.fetch_cursor + 16'h0001;
          next_bus.addr = core_regs.fetch_cursor + 16'h0001;
          next_st = clp_pkg::S_EXEC1;
        end
      end
      clp_pkg::S_EXEC1: begin
        next_st = clp_pkg::S_FETCH;
        next_bus.addr = core_regs.fetch_cursor;
        case (ir)
          clp_pkg::OP_STK_ADD, clp_pkg::OP_IDX_ADD, clp_pkg::OP_ADC_IMM: begin
            next_regs.fetch_cursor = core_regs.fetch_cursor + 16'h0001;
            next_bus.addr = core_regs.fetch_cursor + 16'h0001;
            if (ir == clp_pkg::OP_STK_ADD) begin
              next_regs.stack_pointer = ptr_sum;
            end else if (ir == clp_pkg::OP_IDX_ADD) begin
              next_regs.index_pair = ptr_sum;
            end else begin
              next_regs.acc = adc_sum;
              next_regs.flags_register = adc_flags;
            end
          end
          clp_pkg::OP_BR_NC: begin
            next_opnd = mem_rdata;
            next_regs.fetch_cursor = core_regs.fetch_cursor + 16'h0001;
            next_st = clp_pkg::S_EXEC2;
          end
          clp_pkg::OP_WAIT: begin
            next_regs.flags_register[clp_pkg::FLG_I] = 1'b0;
            next_clk_en = 1'b0;
            next_st = clp_pkg::S_WAIT;
          end
          clp_pkg::OP_STOP: begin
            next_regs.flags_register[clp_pkg::FLG_I] = 1'b0;
            next_clk_en = 1'b0;
            next_st = clp_pkg::S_STOP;
          end
          clp_pkg::OP_SOFT_TRAP: begin
            next_vec = clp_pkg::VEC_TRAP;
            enter_trap = 1'b1;
          end
          clp_pkg::OP_TRAP_RET: begin
            next_regs.stack_pointer = core_regs.stack_pointer + 16'h0001;
            next_bus.addr = core_regs.stack_pointer + 16'h0001;
            next_step = 3'h0;
            next_st = clp_pkg::S_PULL;
          end
          clp_pkg::OP_MASK_CLR: next_regs.flags_register[clp_pkg::FLG_I] = 1'b0;
          clp_pkg::OP_MASK_SET: next_regs.flags_register[clp_pkg::FLG_I] = 1'b1;
          default: ;
        endcase
      end
      clp_pkg::S_EXEC2: begin
        if (!core_regs.flags_register[clp_pkg::FLG_C]) begin
          next_regs.fetch_cursor = ptr_sum;
          next_bus.addr = ptr_sum;
        end else begin
          next_bus.addr = core_regs.fetch_cursor;
        end
        next_st = clp_pkg::S_FETCH;
      end
      clp_pkg::S_STACK: begin
        if (step != clp_pkg::STACK_LAST) begin
          next_bus.addr = core_regs.stack_pointer;
          next_bus.wdata = stack_item;
          next_regs.stack_pointer = core_regs.stack_pointer - 16'h0001;
          next_step = step + 3'h1;
        end else begin
          next_bus.wr = 1'b0;
          next_bus.addr = vec;
          next_regs.flags_register[clp_pkg::FLG_I] = 1'b1;
          next_step = 3'h0;
          next_st = clp_pkg::S_VEC;
        end
      end
      clp_pkg::S_PULL: begin
        unique case (step)
          3'h0: next_regs.flags_register = mem_rdata | clp_pkg::FLG_FIXED;
          3'h1: next_regs.acc = mem_rdata;
          3'h2: next_regs.index_pair[7:0] = mem_rdata;
          3'h3: next_regs.fetch_cursor[15:8] = mem_rdata;
          default: next_regs.fetch_cursor[7:0] = mem_rdata;
        endcase
        if (step != clp_pkg::STACK_LAST) begin
          next_regs.stack_pointer = core_regs.stack_pointer + 16'h0001;
          next_bus.addr = core_regs.stack_pointer + 16'h0001;
          next_step = step + 3'h1;
        end else begin
          next_bus.addr = {core_regs.fetch_cursor[15:8], mem_rdata};
          next_step = 3'h0;
          next_st = clp_pkg::S_FETCH;
          if (!brk_req) begin
            next_brk = 1'b0;
          end
        end
      end
      clp_pkg::S_WAIT: begin
        if (irq_req) begin
          next_clk_en = 1'b1;
          next_vec = clp_pkg::VEC_IRQ;
          enter_trap = 1'b1;
        end
      end
      clp_pkg::S_STOP: begin
        if (ext_irq) begin
          timer_start = 1'b1;
          next_st = clp_pkg::S_STAB;
        end
      end
      clp_pkg::S_STAB: begin
        if (stab_done) begin
          next_clk_en = 1'b1;
          next_vec = clp_pkg::VEC_IRQ;
          enter_trap = 1'b1;
        end
      end
    endcase
    // Stacking starts with the low byte of the fetch cursor
    if (enter_trap) begin
      next_bus.addr = core_regs.stack_pointer;
      next_bus.wr = 1'b1;
      next_bus.wdata = core_regs.fetch_cursor[7:0];
      next_regs.stack_pointer = core_regs.stack_pointer - 16'h0001;
      next_step = 3'h0;
      next_st = clp_pkg::S_STACK;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st         <= clp_pkg::S_VEC;
      core_regs  <= '{acc: 8'h00, index_pair: 16'h0000, stack_pointer: clp_pkg::STK_RST,
                     fetch_cursor: 16'h0000, flags_register: clp_pkg::FLG_RST};
      mem_bus    <= '{addr: clp_pkg::VEC_RESET, wr: 1'b0, wdata: 8'h00};
      ir         <= 8'h00;
      opnd       <= 8'h00;
      step       <= 3'h0;
      vec        <= clp_pkg::VEC_RESET;
      brk_active <= 1'b0;
      cpu_clk_en <= 1'b1;
    end else begin
      st         <= next_st;
      core_regs  <= next_regs;
      mem_bus    <= next_bus;
      ir         <= next_ir;
      opnd       <= next_opnd;
      step       <= next_step;
      vec        <= next_vec;
      brk_active <= next_brk;
      cpu_clk_en <= next_clk_en;
    end
  end

  a_wait_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_WAIT) |=>
      (!core_regs.flags_register[clp_pkg::FLG_I] && !cpu_clk_en && st == clp_pkg::S_WAIT))
    else $error("wait entry wrong");
  a_stop_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_STOP) |=>
      (!core_regs.flags_register[clp_pkg::FLG_I] && !cpu_clk_en && st == clp_pkg::S_STOP))
    else $error("stop entry wrong");
  a_stab_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_STOP && ext_irq) |=> (!cpu_clk_en && st == clp_pkg::S_STAB)[*8])
    else $error("clock resumed before stabilization");
  a_brk_force: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_FETCH && brk_req && !brk_active) |=>
      (ir == clp_pkg::OP_SOFT_TRAP && brk_active && st == clp_pkg::S_STACK))
    else $error("break did not force trap opcode");
  a_brk_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_FETCH && brk_req && !brk_active) |->
      ##6 (st == clp_pkg::S_VEC && mem_bus.addr ==
           ($past(monitor_mode, 6) ? clp_pkg::VEC_TRAP_MON : clp_pkg::VEC_TRAP)))
    else $error("break vector wrong");
  a_brk_boundary: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(brk_active) |-> $past(st == clp_pkg::S_FETCH))
    else $error("break started mid instruction");
  a_brk_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_PULL && step == clp_pkg::STACK_LAST && !brk_req) |=>
      (!brk_active && st == clp_pkg::S_FETCH))
    else $error("trap return did not end break");
  a_stk_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_STK_ADD) |=> (st == clp_pkg::S_FETCH
      && core_regs.stack_pointer == $past(core_regs.stack_pointer) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)}
      && core_regs.flags_register == $past(core_regs.flags_register)))
    else $error("stack add wrong");
  a_idx_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_IDX_ADD) |=> (st == clp_pkg::S_FETCH
      && core_regs.index_pair == $past(core_regs.index_pair) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)}
      && core_regs.flags_register == $past(core_regs.flags_register)))
    else $error("index add wrong");
  a_br_taken: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_BR_NC && !core_regs.flags_register[clp_pkg::FLG_C]) |=>
      ##1 (st == clp_pkg::S_FETCH && core_regs.fetch_cursor ==
           $past(core_regs.fetch_cursor, 2) + 16'h0001 + {{8{$past(mem_rdata[7], 2)}}, $past(mem_rdata, 2)}))
    else $error("branch target wrong");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_FETCH && core_regs.flags_register[clp_pkg::FLG_I] && !(brk_req && !brk_active))
      |=> st == clp_pkg::S_EXEC1)
    else $error("masked interrupt taken");
  a_adc_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_EXEC1 && ir == clp_pkg::OP_ADC_IMM) |=> (core_regs.flags_register[clp_pkg::FLG_C] ==
      (({1'b0, $past(core_regs.acc)} + {1'b0, $past(mem_rdata)}
        + {8'h00, $past(core_regs.flags_register[clp_pkg::FLG_C])}) > 9'h0FF)))
    else $error("carry flag wrong");
  a_lp_wake: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st == clp_pkg::S_WAIT) |=> (st == clp_pkg::S_WAIT || (st == clp_pkg::S_STACK && cpu_clk_en)))
    else $error("wait left without interrupt entry");
endmodule // clp_core

// ==== tb/clp_mem_model.sv ====
// Memory partner: 64 KB byte array with zero-latency read and write on the clock edge.
// Assumes the core shows one address per cycle and holds wr for that cycle only.
`timescale 1ns/1ps
module clp_mem_model (
  // Clock
  input  wire logic              clk_sys,
  // Core bus
  input  wire clp_pkg::clp_bus_t mem_bus,
  output logic [7:0]             mem_rdata
);
  logic [7:0] mem [0:65535];

  // Same-cycle answer, no wait states
  assign mem_rdata = mem[mem_bus.addr];

  always @(posedge clk_sys) begin
    if (mem_bus.wr === 1'b1) begin
      mem[mem_bus.addr] <= mem_bus.wdata;
    end
  end

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule // clp_mem_model

// ==== tb/cpu_lowpower_break_ops_bench.sv ====
// Self-checking bench for the core slice: arithmetic, low-power entry and exit, break trap.
// Assumes the memory partner in clp_mem_model and inputs driven at the falling edge.
`timescale 1ns/1ps
module cpu_lowpower_break_ops_bench;
  logic               clk_sys;
  logic               sys_rst;
  clp_pkg::clp_bus_t  bus;
  logic [7:0]         rdata;
  logic               brk_req;
  logic               monitor_mode;
  logic               irq_req;
  logic               ext_irq;
  clp_pkg::clp_regs_t regs;
  logic               clk_en;
  logic               brk_act;
  int                 bad_count;
  int                 total_checks;
  int                 seed;
  int                 n;
  logic [7:0]         ii;
  logic [7:0]         ss;
  logic [7:0]         xx;
  logic [15:0]        vec;

  clp_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .mem_bus(bus), .mem_rdata(rdata),
    .brk_req(brk_req), .monitor_mode(monitor_mode), .irq_req(irq_req), .ext_irq(ext_irq),
    .core_regs(regs), .cpu_clk_en(clk_en), .brk_active(brk_act));
  clp_mem_model i_mem (.clk_sys(clk_sys), .mem_bus(bus), .mem_rdata(rdata));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // Flags after add-with-carry from a zero accumulator and clear carry
  function automatic logic [7:0] adc_flags(input logic [7:0] r);
    return 8'h68 | {5'h00, r[7], (r == 8'h00), 1'b0};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_addr(input logic [15:0] a, input int lim, output int k);
    k = 0;
    while (bus.addr !== a && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    check("address reached", bus.addr, a);
  endtask

  task automatic wait_en(input logic v, input int lim, output int k);
    k = 0;
    while (clk_en !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    check("clock enable", {15'h0000, clk_en}, {15'h0000, v});
  endtask

  task automatic load();
    logic [7:0] p [0:12];
    p = '{8'hA9, ii, 8'hA7, ss, 8'hAF, xx, 8'h24, 8'h02, 8'h8E, 8'h00, 8'h9A, 8'h8F, 8'h8E};
    for (int a = 0; a < 13; a++) i_mem.put(16'h1000 + 16'(a), p[a]);
    for (int a = 16'h100D; a < 16'h1100; a++) i_mem.put(16'(a), 8'h9D);
    i_mem.put(16'hFFFE, 8'h10);
    i_mem.put(16'hFFFF, 8'h00);
    i_mem.put(16'hFFFA, 8'h20);
    i_mem.put(16'hFFFB, 8'h00);
    i_mem.put(16'hFFFC, 8'h30);
    i_mem.put(16'hFFFD, 8'h00);
    i_mem.put(16'hFEFC, 8'h30);
    i_mem.put(16'hFEFD, 8'h00);
    i_mem.put(16'h2000, 8'h80);
    i_mem.put(16'h3000, 8'hA9);
    i_mem.put(16'h3001, 8'hFF);
    i_mem.put(16'h3002, 8'h80);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    seed = 32'hdcccaa0a;
    bad_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    brk_req = 1'b0;
    monitor_mode = 1'b0;
    irq_req = 1'b0;
    ext_irq = 1'b0;
    for (int it = 0; it < 3; it++) begin
      ii = (it == 0) ? 8'h00 : 8'($random(seed));
      ss = (it == 1) ? 8'h80 : 8'($random(seed));
      xx = 8'($random(seed));
      load();
      @(negedge clk_sys);
      sys_rst = 1'b1;
      repeat (6) @(negedge clk_sys);
      check("stack reset", regs.stack_pointer, 16'h00FF);
      check("flags reset", {8'h00, regs.flags_register}, 16'h0068);
      sys_rst = 1'b0;
      irq_req = 1'b1;
      wait_addr(16'h1000, 10, n);
      wait_addr(16'h1002, 4, n);
      check("acc", {8'h00, regs.acc}, {8'h00, ii});
      check("adc flags", {8'h00, regs.flags_register}, {8'h00, adc_flags(ii)});
      wait_addr(16'h1004, 4, n);
      check("stack add cycles", 16'(n), 16'h0002);
      check("stack pointer", regs.stack_pointer, 16'h00FF + sx(ss));
      wait_addr(16'h1006, 4, n);
      irq_req = 1'b0;
      check("index add cycles", 16'(n), 16'h0002);
      check("index pair", regs.index_pair, sx(xx));
      check("flags kept", {8'h00, regs.flags_register}, {8'h00, adc_flags(ii)});
      wait_addr(16'h100A, 5, n);
      check("branch cycles", 16'(n), 16'h0003);
      check("masked request ignored", regs.fetch_cursor, 16'h100A);
      wait_en(1'b0, 10, n);
      check("mask in wait", {15'h0000, regs.flags_register[3]}, 16'h0000);
      repeat (5) @(negedge clk_sys);
      check("idle holds", {15'h0000, clk_en}, 16'h0000);
      irq_req = 1'b1;
      wait_addr(16'hFFFA, 12, n);
      irq_req = 1'b0;
      wait_addr(16'h100C, 20, n);
      check("mask after wait", {15'h0000, regs.flags_register[3]}, 16'h0000);
      wait_en(1'b0, 10, n);
      check("mask in stop", {15'h0000, regs.flags_register[3]}, 16'h0000);
      irq_req = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("stop ignores irq", {15'h0000, clk_en}, 16'h0000);
      irq_req = 1'b0;
      ext_irq = 1'b1;
      wait_en(1'b1, 300, n);
      ext_irq = 1'b0;
      check("stabilization", {15'h0000, (n >= 250 && n <= 260)}, 16'h0001);
      wait_addr(16'hFFFA, 12, n);
      wait_addr(16'h100D, 20, n);
      check("mask after stop", {15'h0000, regs.flags_register[3]}, 16'h0000);
      monitor_mode = it[0];
      vec = it[0] ? 16'hFEFC : 16'hFFFC;
      wait_addr(16'h1010, 10, n);
      brk_req = 1'b1;
      wait_addr(vec, 12, n);
      check("break active", {15'h0000, brk_act}, 16'h0001);
      brk_req = 1'b0;
      wait_addr(16'h3000, 4, n);
      // Handler adds FF to the saved accumulator: carry and half carry get exercised
      repeat (2) @(negedge clk_sys);
      check("handler carry", {15'h0000, regs.flags_register[0]}, {15'h0000, ii != 8'h00});
      check("handler half carry", {15'h0000, regs.flags_register[4]}, {15'h0000, ii[3:0] != 4'h0});
      check("handler sum", {8'h00, regs.acc}, {8'h00, 8'(ii + 8'hFF)});
      n = 0;
      while (brk_act !== 1'b0 && n < 15) begin
        @(negedge clk_sys);
        n++;
      end
      check("break ended", {15'h0000, brk_act}, 16'h0000);
      check("resume address", bus.addr, 16'h1010);
      @(negedge clk_sys);
      check("resumed page", {8'h00, bus.addr[15:8]}, 16'h0010);
      $display("test %0d done", it);
    end
    give_verdict();
  end
endmodule // cpu_lowpower_break_ops_bench
